// [inc/pml_pkg.sv]
// package: constants and types for the private memory link slave
package pml_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 22;
    localparam int MEM_AW = 10;
    // cycle type codes {write_indicate_n, byte_select_n}
    localparam logic [1:0] CT_READ = 2'h3;
    localparam logic [1:0] CT_RMW = 2'h2;
    localparam logic [1:0] CT_WORD_WR = 2'h1;
    localparam logic [1:0] CT_BYTE_WR = 2'h0;
    localparam logic LINE_NEG = 1'h1;
    localparam logic LINE_ASS = 1'h0;
    // strobe timing in cycles of the 125 MHz clock
    localparam int CLK_PERIOD_NS = 8;
    localparam int STB_LOW_NS = 16;
    localparam int STB_LOW_CYC = (STB_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SECOND_HOLD_NS = 24;
    localparam int SECOND_HOLD_CYC = (SECOND_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WBUF_DEPTH = 4;

    // master control lines as seen at the slave
    typedef struct packed {
        logic cycle_active_n;
        logic block_pace_n;
        logic write_strobe_n;
        logic write_indicate_n;
        logic byte_select_n;
        logic adapter_memory_space_n;
        logic link_busy_n;
    } pml_ctl_t;

    // slave response lines
    typedef struct packed {
        logic slave_selected_n;
        logic read_strobe_n;
        logic upper_byte_parity_n;
        logic lower_byte_parity_n;
        logic slave_buffer_full_n;
    } pml_rsp_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_STB_LO = 3'h3,
        ST_STB_HI = 3'h2,
        ST_SECOND = 3'h6,
        ST_PAIR_WAIT = 3'h7,
        ST_WRITE = 3'h5,
        ST_DONE = 3'h4
    } pml_state_t;
endpackage

// [hw/pml_parity.sv]
// byte parity generator for read data
`timescale 1ns/1ps
module pml_parity
    import pml_pkg::*;
(
    // data
    input wire logic [DATA_W-1:0] data_in,
    // parity lines, active low encoding
    output logic upper_par_n_out,
    output logic lower_par_n_out
);
    // odd parity high byte, even parity low byte; line low means parity bit set
    always_comb begin
        upper_par_n_out = ~(~(^data_in[15:8]));
        lower_par_n_out = ~(^data_in[7:0]);
    end
endmodule

// [hw/pml_slave.sv]
// private memory link memory slave
`timescale 1ns/1ps
module pml_slave
    import pml_pkg::*;
#(
    parameter logic [ADDR_W-1:0] BASE_ADDR = 22'h000000,
    parameter int AW = MEM_AW,
    parameter int DRAIN_CYC = 2
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // link pins
    input wire pml_ctl_t ctl_in,
    input wire logic [ADDR_W-1:0] muxed_addr_data_lines_in,
    output logic [DATA_W-1:0] muxed_addr_data_lines_out,
    output logic muxed_addr_data_lines_oe_out,
    output pml_rsp_t rsp_out
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: pins are asynchronous to our clock
    pml_ctl_t ctl_s1_r, ctl_s2_r, ctl_prev_r;
    logic [ADDR_W-1:0] dal_s1_r, dal_s2_r;
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctl_s1_r <= '1;
            ctl_s2_r <= '1;
            ctl_prev_r <= '1;
            dal_s1_r <= '0;
            dal_s2_r <= '0;
        end else begin
            ctl_s1_r <= ctl_in;
            ctl_s2_r <= ctl_s1_r;
            ctl_prev_r <= ctl_s2_r;
            dal_s1_r <= muxed_addr_data_lines_in;
            dal_s2_r <= dal_s1_r;
        end
    end
    function automatic logic fall(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction
    logic cyc_start, cyc_end, wstb_fall, pace_fall, addr_hit;
    always_comb begin
        cyc_start = fall(ctl_prev_r.cycle_active_n, ctl_s2_r.cycle_active_n);
        cyc_end = ~ctl_prev_r.cycle_active_n & ctl_s2_r.cycle_active_n;
        wstb_fall = fall(ctl_prev_r.write_strobe_n, ctl_s2_r.write_strobe_n);
        pace_fall = fall(ctl_prev_r.block_pace_n, ctl_s2_r.block_pace_n);
        addr_hit = (dal_s2_r[ADDR_W-1:AW+1] == BASE_ADDR[ADDR_W-1:AW+1]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage and write buffer
    logic [DATA_W-1:0] mem_r [0:(1<<AW)-1];
    logic [$clog2(WBUF_DEPTH+1)-1:0] wcnt_r, wcnt_nxt;
    logic [7:0] drain_r, drain_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // cycle state
    pml_state_t st_r, st_nxt;
    logic [AW-1:0] addr_r, addr_nxt;
    logic [1:0] ctype_r, ctype_nxt;
    logic hi_r, hi_nxt, sel_r, sel_nxt, mute_r, mute_nxt, block_r, block_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic rstb_r, rstb_nxt, oe_r, oe_nxt, wr_now;
    logic [DATA_W-1:0] rdata_r, rdata_nxt, merged;
    always_comb begin
        st_nxt = st_r;
        addr_nxt = addr_r;
        ctype_nxt = ctype_r;
        hi_nxt = hi_r;
        sel_nxt = sel_r;
        mute_nxt = mute_r;
        block_nxt = block_r;
        cnt_nxt = cnt_r;
        rstb_nxt = LINE_NEG;
        oe_nxt = oe_r;
        rdata_nxt = rdata_r;
        wr_now = 1'b0;
        if (cyc_end) begin
            st_nxt = ST_IDLE;
            sel_nxt = 1'b0;
            mute_nxt = 1'b0; // adapter space only lasts for its own cycle
            oe_nxt = 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (cyc_start && addr_hit) begin
                        addr_nxt = dal_s2_r[AW:1]; // address stands at cycle start
                        hi_nxt = dal_s2_r[0];
                        ctype_nxt = {ctl_s2_r.write_indicate_n, ctl_s2_r.byte_select_n};
                        sel_nxt = 1'b1;
                        mute_nxt = ~ctl_s2_r.adapter_memory_space_n;
                        block_nxt = ~ctl_s2_r.block_pace_n;
                        st_nxt = ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (mute_r) begin
                        st_nxt = ST_DONE;
                    end else if (ctype_r == CT_READ || ctype_r == CT_RMW) begin
                        rdata_nxt = mem_r[addr_r];
                        oe_nxt = 1'b1;
                        rstb_nxt = LINE_ASS; // strobe falls with the data, low for the full count
                        cnt_nxt = 4'(STB_LOW_CYC);
                        st_nxt = ST_STB_LO;
                    end else begin
                        st_nxt = ST_WRITE;
                    end
                end
                ST_STB_LO: begin
                    rstb_nxt = LINE_ASS;
                    cnt_nxt = cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        rstb_nxt = LINE_NEG;
                        cnt_nxt = 4'(SECOND_HOLD_CYC);
                        st_nxt = ST_STB_HI;
                    end
                end
                ST_STB_HI: begin // first word held, then second shown in block mode
                    cnt_nxt = cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        if (block_r) begin
                            addr_nxt = addr_r + AW'(1);
                            rdata_nxt = mem_r[addr_r + AW'(1)];
                            cnt_nxt = 4'(SECOND_HOLD_CYC);
                            st_nxt = ST_SECOND;
                        end else begin
                            st_nxt = ST_DONE;
                        end
                    end
                end
                ST_SECOND: begin
                    cnt_nxt = cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        addr_nxt = addr_r + AW'(1);
                        st_nxt = ST_PAIR_WAIT;
                    end
                end
                ST_PAIR_WAIT: begin
                    if (pace_fall) begin // another pair only on a pace pulse
                        rdata_nxt = mem_r[addr_r];
                        rstb_nxt = LINE_ASS;
                        cnt_nxt = 4'(STB_LOW_CYC);
                        st_nxt = ST_STB_LO;
                    end
                end
                ST_WRITE: begin
                    if (wstb_fall && wcnt_r != 3'(WBUF_DEPTH)) begin
                        wr_now = 1'b1;
                        st_nxt = ST_DONE;
                    end
                end
                default: st_nxt = ST_DONE;
            endcase
        end
    end
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= ST_IDLE;
            addr_r <= '0;
            ctype_r <= CT_READ;
            hi_r <= 1'b0;
            sel_r <= 1'b0;
            mute_r <= 1'b0;
            block_r <= 1'b0;
            cnt_r <= '0;
            rstb_r <= LINE_NEG;
            oe_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            st_r <= st_nxt;
            addr_r <= addr_nxt;
            ctype_r <= ctype_nxt;
            hi_r <= hi_nxt;
            sel_r <= sel_nxt;
            mute_r <= mute_nxt;
            block_r <= block_nxt;
            cnt_r <= cnt_nxt;
            rstb_r <= rstb_nxt;
            oe_r <= oe_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write buffer: buffered writes retire from the count after a drain delay
    always_comb begin
        wcnt_nxt = wcnt_r;
        drain_nxt = drain_r;
        if (wcnt_r != '0) begin
            drain_nxt = drain_r + 8'h01;
            if (drain_r == 8'(DRAIN_CYC)) begin
                drain_nxt = '0;
                wcnt_nxt = wcnt_r - 3'h1;
            end
        end
        if (wr_now) begin
            wcnt_nxt = wcnt_nxt + 3'h1;
        end
        merged = mem_r[addr_r];
        if (ctype_r == CT_BYTE_WR && hi_r) begin
            merged[15:8] = dal_s2_r[15:8];
        end else if (ctype_r == CT_BYTE_WR) begin
            merged[7:0] = dal_s2_r[7:0];
        end else begin
            merged = dal_s2_r[DATA_W-1:0];
        end
    end
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wcnt_r <= '0;
            drain_r <= '0;
        end else begin
            wcnt_r <= wcnt_nxt;
            drain_r <= drain_nxt;
        end
    end
    // data written immediately; the buffer count only models throttling
    always_ff @(posedge ref_clk_in) begin
        if (wr_now) begin
            mem_r[addr_r] <= merged;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    logic up_n, lo_n;
    pml_parity u_par (
        .data_in(rdata_nxt),
        .upper_par_n_out(up_n),
        .lower_par_n_out(lo_n)
    );
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rsp_out <= '1;
            muxed_addr_data_lines_out <= '0;
            muxed_addr_data_lines_oe_out <= 1'b0;
        end else begin
            rsp_out.slave_selected_n <= ~sel_nxt;
            rsp_out.read_strobe_n <= rstb_nxt;
            rsp_out.upper_byte_parity_n <= oe_nxt ? up_n : LINE_NEG;
            rsp_out.lower_byte_parity_n <= oe_nxt ? lo_n : LINE_NEG;
            rsp_out.slave_buffer_full_n <= ~(wcnt_nxt == 3'(WBUF_DEPTH) && !mute_nxt);
            muxed_addr_data_lines_out <= rdata_nxt;
            muxed_addr_data_lines_oe_out <= oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence strobe_pulse_s;
        !rsp_out.read_strobe_n [*2] ##1 rsp_out.read_strobe_n;
    endsequence
    reset_idle_a: assert property ($rose(rst_n_in) |-> rsp_out == '1)
        else $error("lines not negated after reset");
    strobe_width_a: assert property ($fell(rsp_out.read_strobe_n) |-> strobe_pulse_s)
        else $error("read strobe width wrong");
    strobe_sel_a: assert property (!rsp_out.read_strobe_n |->
        !rsp_out.slave_selected_n && muxed_addr_data_lines_oe_out) else $error("read strobe without selection");
    odd_upper_a: assert property (muxed_addr_data_lines_oe_out |->
        ^{muxed_addr_data_lines_out[15:8], ~rsp_out.upper_byte_parity_n}) else $error("upper parity not odd");
    even_lower_a: assert property (muxed_addr_data_lines_oe_out |->
        !(^{muxed_addr_data_lines_out[7:0], ~rsp_out.lower_byte_parity_n})) else $error("lower parity not even");
    mute_quiet_a: assert property (mute_r |-> rsp_out.read_strobe_n && !muxed_addr_data_lines_oe_out)
        else $error("muted slave responded");
    select_hit_a: assert property (st_r == ST_IDLE && cyc_start && addr_hit && !cyc_end |=>
        ##1 !rsp_out.slave_selected_n) else $error("selection missing");
    full_count_a: assert property (!rsp_out.slave_buffer_full_n |-> $past(wcnt_nxt) == 3'(WBUF_DEPTH))
        else $error("buffer full without full buffer");
    drop_end_a: assert property (cyc_end |=> ##1 rsp_out.slave_selected_n && !muxed_addr_data_lines_oe_out)
        else $error("selection held after cycle end");
endmodule

// [sim/pml_master_model.sv]
// master side model of the private memory link
`timescale 1ns/1ps
module pml_master_model
    import pml_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // link pins
    output pml_ctl_t ctl_out,
    output logic [ADDR_W-1:0] lines_out,
    input wire pml_rsp_t rsp_in,
    input wire logic [DATA_W-1:0] data_in,
    // captured words with parity
    output logic cap_valid_out,
    output logic [DATA_W+1:0] cap_out
);
    initial begin
        ctl_out = '1;
        lines_out = '0;
        cap_valid_out = 1'b0;
        cap_out = '0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    // bounded wait for a response bit to reach a level
    task automatic wait_bit(input int b, input logic lvl, input int lim, output logic ok);
        logic [4:0] r;
        ok = 1'b0;
        for (int i = 0; i < lim && !ok; i++) begin
            @(negedge ref_clk_in);
            r = rsp_in;
            ok = (r[b] === lvl);
        end
    endtask
    task automatic start(input logic [ADDR_W-1:0] a, input logic [1:0] code, input logic blk,
                         input logic adp, output logic sel);
        logic ok;
        wait_bit(0, LINE_NEG, 800, ok);
        lines_out <= a;
        {ctl_out.write_indicate_n, ctl_out.byte_select_n} <= code;
        ctl_out.adapter_memory_space_n <= ~adp;
        ctl_out.block_pace_n <= ~blk;
        ctl_out.link_busy_n <= LINE_ASS;
        tick(1);
        ctl_out.cycle_active_n <= LINE_ASS;
        tick(3);
        wait_bit(4, LINE_ASS, 20, sel);
    endtask
    task automatic finish();
        ctl_out <= '1;
        lines_out <= ~lines_out; // released lines show the inverse of their last value, which after a read is the cycle's address again
        tick(6);
    endtask
    task automatic grab();
        cap_out <= {rsp_in.upper_byte_parity_n, rsp_in.lower_byte_parity_n, data_in};
        cap_valid_out <= 1'b1;
        tick(1);
        cap_valid_out <= 1'b0;
    endtask
    task automatic write(input logic [ADDR_W-1:0] a, input logic [1:0] code,
                         input logic [DATA_W-1:0] d, output logic sel);
        start(a, code, 1'b0, 1'b0, sel);
        lines_out <= {{(ADDR_W-DATA_W){1'b0}}, d};
        tick(1);
        ctl_out.write_strobe_n <= LINE_ASS;
        tick(3);
        ctl_out.write_strobe_n <= LINE_NEG;
        tick(2);
        finish();
    endtask
    task automatic read(input logic [ADDR_W-1:0] a, input logic [1:0] code, input int pairs,
                        input logic adp, output logic sel, output logic ok);
        logic hi;
        start(a, code, pairs > 0, adp, sel);
        lines_out <= ~lines_out;
        ok = 1'b1;
        for (int p = 0; p < (pairs > 0 ? pairs : 1) && !adp && sel; p++) begin
            if (p > 0) begin
                tick(1); // the pace line must show its negation before the next pulse
                ctl_out.block_pace_n <= LINE_ASS;
                tick(3);
                ctl_out.block_pace_n <= LINE_NEG;
            end
            wait_bit(3, LINE_ASS, 40, hi);
            ok &= hi;
            wait_bit(3, LINE_NEG, 10, hi);
            ok &= hi;
            grab();
            if (pairs > 0) begin
                tick(SECOND_HOLD_CYC);
                grab();
                ctl_out.block_pace_n <= LINE_NEG;
            end
        end
        if (adp) tick(12);
        finish();
    endtask
endmodule

// [sim/tb_top.sv]
// self-checking bench for the private memory link slave
`timescale 1ns/1ps
module tb_top
    import pml_pkg::*;
;
    localparam logic [ADDR_W-1:0] BASE = 22'h000800;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    pml_ctl_t ctl;
    pml_rsp_t rsp;
    logic [ADDR_W-1:0] m_lines;
    logic [ADDR_W-1:0] lines_w;
    logic [DATA_W-1:0] dut_data;
    logic dut_oe;
    logic cap_valid;
    logic [DATA_W+1:0] cap;
    logic [DATA_W+1:0] exp_q[$];
    logic [DATA_W-1:0] shadow [0:7];
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int stb_falls = 0;
    logic full_seen = 1'b0;
    logic prev_stb = 1'b1;

    always #4 ref_clk_in = ~ref_clk_in;
    // slave owns the low lines while it drives them
    assign lines_w = dut_oe ? {m_lines[ADDR_W-1:DATA_W], dut_data} : m_lines;

    // a long drain time lets four quick writes fill the buffer
    pml_slave #(.BASE_ADDR(BASE), .AW(MEM_AW), .DRAIN_CYC(149)) dut (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ctl_in(ctl),
        .muxed_addr_data_lines_in(lines_w), .muxed_addr_data_lines_out(dut_data),
        .muxed_addr_data_lines_oe_out(dut_oe), .rsp_out(rsp));
    pml_master_model m (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ctl_out(ctl), .lines_out(m_lines),
        .rsp_in(rsp), .data_in(lines_w[DATA_W-1:0]), .cap_valid_out(cap_valid), .cap_out(cap));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [DATA_W+1:0] got, input logic [DATA_W+1:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string msg);
        chk({17'h0, got}, {17'h0, exp}, msg);
    endtask
    task automatic expect_word(input int w);
        exp_q.push_back({^shadow[w][15:8], ~^shadow[w][7:0], shadow[w]});
    endtask
    function automatic logic [ADDR_W-1:0] waddr(input int w);
        return BASE | ADDR_W'(w << 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        prev_stb <= rsp.read_strobe_n;
        if (prev_stb === 1'b1 && rsp.read_strobe_n === 1'b0) begin
            stb_falls <= stb_falls + 1;
        end
        if (rsp.slave_buffer_full_n === LINE_ASS) begin
            full_seen <= 1'b1;
        end
        if (cap_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk1(1'b1, 1'b0, "unexpected read word");
            end else begin
                chk(cap, exp_q.pop_front(), "read word");
            end
        end
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic sel;
        logic ok;
        logic [7:0] b;
        int n;
        void'($urandom(49));
        repeat (5) @(negedge ref_clk_in);
        chk({12'h0, rsp, dut_oe}, {12'h0, 5'h1f, 1'h0}, "lines in reset");
        rst_n_in = 1'b1;
        @(negedge ref_clk_in);
        chk({12'h0, rsp, dut_oe}, {12'h0, 5'h1f, 1'h0}, "lines after reset");
        m.read(22'h001000, CT_READ, 0, 1'b0, sel, ok);
        chk1(sel, 1'b0, "foreign address selected");
        for (int w = 0; w < 8; w++) begin
            shadow[w] = 16'($urandom);
            m.write(waddr(w), CT_WORD_WR, shadow[w], sel);
            chk1(sel, 1'b1, "write select");
            if (w == 3) chk1(full_seen, 1'b1, "buffer full after four writes");
        end
        for (int w = 4; w < 8; w++) begin
            b = 8'($urandom);
            m.write(waddr(w) | ADDR_W'(w & 1), CT_BYTE_WR, {b, b}, sel);
            if (w & 1) shadow[w][15:8] = b;
            else shadow[w][7:0] = b;
        end
        for (int w = 0; w < 8; w++) begin
            expect_word(w);
            m.read(waddr(w), w[0] ? CT_RMW : CT_READ, 0, 1'b0, sel, ok);
            chk1(ok, 1'b1, "read strobe pulse");
        end
        for (int w = 1; w < 7; w++) expect_word(w);
        m.read(waddr(1), CT_READ, 3, 1'b0, sel, ok);
        chk1(ok, 1'b1, "block read strobes");
        n = stb_falls;
        m.read(waddr(2), CT_READ, 0, 1'b1, sel, ok);
        chk1(sel, 1'b1, "adapter space select");
        chk1(stb_falls == n, 1'b1, "adapter space silent");
        chk1(exp_q.size() == 0, 1'b1, "words left unread");
        conclude();
    end
endmodule
